// ==== design/dirf_pkg.sv ====
// constants for the drive information record formatter
// Behaviour
// - four-byte record per written sector, third group
// - control positions from 8193 grouped by four
// - byte one bit 6 shows verify-after-write
// - relocation flag zero when not relocated
// - flag one verify error, zero write error
// - byte one bits 4..0 vendor relocation reason
// - attempt field zero when not relocated
// - attempt field holds attempt number minus one
// - 20-bit serial packed across bytes two to four
// - bit 7 of bytes one, two zero
// - special sectors zero relocation fields
`default_nettype none
package dirf_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CTX = 12'h004;
  localparam logic [11:0] ADDR_SERIAL = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_RECORD = 12'h010;
  localparam int CTX_VERIFY = 0;
  localparam int CTX_RELOC = 1;
  localparam int CTX_VERR = 2;
  localparam int CTX_SPECIAL = 3;
  localparam int CTX_ATTEMPT = 4;
  localparam int CTX_CAUSE = 8;
  localparam logic [13:0] CTRL_FIRST_POS = 14'h2001;
  localparam logic [13:0] POS_PER_GROUP = 14'h0004;
  localparam logic [1:0] RECORD_GROUP = 2'h2;
  localparam logic [31:0] CTX_RESET = 32'h0000_0000;
  localparam logic [19:0] SERIAL_RESET = 20'h00000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : dirf_pkg
`default_nettype wire

// ==== design/dirf_formatter.sv ====
// drive information record formatter with axi4-lite context registers
`default_nettype none
module dirf_formatter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pos_valid,
  input wire logic [13:0] pos_index,
  output logic [7:0] ctl_byte,
  output logic ctl_byte_valid,
  output logic [1:0] ctl_group
);
  logic [31:0] ctx_q;
  logic [19:0] serial_q;
  logic [15:0] emitted_q;
  logic have_aw_q;
  logic have_w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [7:0] rec_b1;
  logic [7:0] rec_b2;
  logic [7:0] rec_b3;
  logic [7:0] rec_b4;
  logic is_reloc;
  logic [13:0] rel;
  logic [1:0] sel;
  logic in_rec;

  // record assembly
  always_comb begin
    is_reloc = ctx_q[dirf_pkg::CTX_RELOC] & ~ctx_q[dirf_pkg::CTX_SPECIAL];
    rec_b1 = 8'h00;
    rec_b1[6] = ctx_q[dirf_pkg::CTX_VERIFY];
    rec_b1[5] = is_reloc & ctx_q[dirf_pkg::CTX_VERR];
    rec_b1[4:0] = ctx_q[dirf_pkg::CTX_SPECIAL] ? 5'h00 : ctx_q[dirf_pkg::CTX_CAUSE +: 5];
    rec_b2 = 8'h00;
    rec_b2[6:4] = is_reloc ? ctx_q[dirf_pkg::CTX_ATTEMPT +: 3] : 3'h0;
    rec_b2[3:0] = serial_q[19:16];
    rec_b3 = serial_q[15:8];
    rec_b4 = serial_q[7:0];
  end

  // control position to group and byte
  always_comb begin
    rel = pos_index - dirf_pkg::CTRL_FIRST_POS;
    sel = rel[1:0];
    in_rec = pos_valid && pos_index >= dirf_pkg::CTRL_FIRST_POS
      && rel < (dirf_pkg::POS_PER_GROUP * 14'h0003)
      && rel[3:2] == dirf_pkg::RECORD_GROUP;
  end

  // byte output, one per requested position in the record group
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_byte <= 8'h00;
      ctl_byte_valid <= 1'b0;
      ctl_group <= 2'h0;
      emitted_q <= 16'h0000;
    end else begin
      ctl_byte_valid <= in_rec;
      ctl_group <= rel[3:2];
      if (in_rec) begin
        emitted_q <= emitted_q + 16'h0001;
        case (sel)
          2'd0: ctl_byte <= rec_b1;
          2'd1: ctl_byte <= rec_b2;
          2'd2: ctl_byte <= rec_b3;
          default: ctl_byte <= rec_b4;
        endcase
      end
    end
  end

  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dirf_pkg::RESP_OKAY;
      ctx_q <= dirf_pkg::CTX_RESET;
      serial_q <= dirf_pkg::SERIAL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (have_aw_q && have_w_q && !s_axi_bvalid) begin
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= dirf_pkg::RESP_OKAY;
        case (awaddr_q[11:2])
          dirf_pkg::ADDR_CTX[11:2]: begin
            for (int i = 0; i < 4; i++) begin
              if (wstrb_q[i]) ctx_q[i*8 +: 8] <= wdata_q[i*8 +: 8];
            end
          end
          dirf_pkg::ADDR_SERIAL[11:2]: begin
            for (int i = 0; i < 2; i++) begin
              if (wstrb_q[i]) serial_q[i*8 +: 8] <= wdata_q[i*8 +: 8];
            end
            if (wstrb_q[2]) serial_q[19:16] <= wdata_q[19:16];
          end
          dirf_pkg::ADDR_CTRL[11:2]: begin
            s_axi_bresp <= dirf_pkg::RESP_OKAY;
          end
          default: s_axi_bresp <= dirf_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !have_aw_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !have_w_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dirf_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= dirf_pkg::RESP_OKAY;
        case (s_axi_araddr[11:2])
          dirf_pkg::ADDR_CTRL[11:2]: s_axi_rdata <= 32'h0000_0000;
          dirf_pkg::ADDR_CTX[11:2]: s_axi_rdata <= ctx_q;
          dirf_pkg::ADDR_SERIAL[11:2]: s_axi_rdata <= {12'h000, serial_q};
          dirf_pkg::ADDR_STATUS[11:2]: s_axi_rdata <= {16'h0000, emitted_q};
          dirf_pkg::ADDR_RECORD[11:2]: s_axi_rdata <= {rec_b1, rec_b2, rec_b3, rec_b4};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= dirf_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  unused_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_byte_valid && $past(sel) <= 2'd1 |-> !ctl_byte[7])
    else $error("unassigned bit seven set");
  verify_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rec_b1[6] == ctx_q[dirf_pkg::CTX_VERIFY]) else $error("verify bit wrong");
  flag_noreloc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctx_q[dirf_pkg::CTX_RELOC] |-> !rec_b1[5]) else $error("flag set unrelocated");
  flag_verr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    is_reloc |-> rec_b1[5] == ctx_q[dirf_pkg::CTX_VERR]) else $error("flag cause wrong");
  attempt_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctx_q[dirf_pkg::CTX_RELOC] |-> rec_b2[6:4] == 3'h0) else $error("attempt nonzero");
  attempt_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
    is_reloc |-> rec_b2[6:4] == ctx_q[6:4]) else $error("attempt code wrong");
  special_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctx_q[dirf_pkg::CTX_SPECIAL] |-> rec_b1[5:0] == 6'h00 && rec_b2[6:4] == 3'h0)
    else $error("special sector fields nonzero");
  serial_pack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    {rec_b2[3:0], rec_b3, rec_b4} == serial_q) else $error("serial packing wrong");
  emit_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
    in_rec && sel == 2'd2 |=> ctl_byte_valid && ctl_byte == $past(serial_q[15:8]))
    else $error("third byte wrong");
  group_pos_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pos_valid && pos_index == 14'h2009 |=> ctl_byte_valid && ctl_group == 2'h2)
    else $error("first record position missed");
  group_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl_byte_valid |-> ctl_group == dirf_pkg::RECORD_GROUP)
    else $error("byte outside third group");
  other_pos_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !in_rec |=> !ctl_byte_valid) else $error("byte for foreign position");
endmodule : dirf_formatter
`default_nettype wire

// ==== tb/dirf_asm_model.sv ====
// assembler model that asks for control positions and collects record bytes
`default_nettype none
module dirf_asm_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic slow,
  output logic pos_valid,
  output logic [13:0] pos_index,
  input wire logic [7:0] ctl_byte,
  input wire logic ctl_byte_valid,
  input wire logic [1:0] ctl_group,
  output logic [31:0] rec,
  output logic [1:0] grp,
  output logic [3:0] cnt,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] p = 14'h0000;
  initial begin
    pos_valid = 1'b0;
    pos_index = 14'h0000;
    rec = 32'h0;
    grp = 2'h0;
    cnt = 4'h0;
  end
  assign busy = (p != 14'h0000) || pos_valid;
  always @(posedge aclk) begin
    if (ctl_byte_valid) begin
      rec <= {rec[23:0], ctl_byte};
      grp <= ctl_group;
      cnt <= cnt + 4'h1;
    end
    if (go) begin
      cnt <= 4'h0;
      p <= 14'h2001;
    end else if (p != 14'h0000 && !(slow && $urandom_range(1))) begin
      pos_valid <= 1'b1;
      pos_index <= p;
      p <= (p == 14'h2010) ? 14'h0000 : p + 14'h0001;
    end else begin
      pos_valid <= 1'b0;
      pos_index <= ~pos_index;
    end
  end
endmodule : dirf_asm_model
`default_nettype wire

// ==== tb/drive_info_record_formatter_bench.sv ====
// random and corner tests of the drive information record formatter
`default_nettype none
module drive_info_record_formatter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, go = 0, slow = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, rdt, rec, c;
  logic [19:0] sn;
  logic [1:0] bresp, rresp, grp, lg, resp;
  logic awr, wrd, bv, arr, rv, pv, cbv, busy;
  logic [13:0] pi;
  logic [7:0] cb;
  logic [3:0] cnt;
  int error_cnt = 0, check_count = 0;
  always #2 aclk = ~aclk;
  dirf_formatter u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .pos_valid(pv),
    .pos_index(pi), .ctl_byte(cb), .ctl_byte_valid(cbv), .ctl_group(grp));
  dirf_asm_model u_asm (.aclk(aclk), .go(go), .slow(slow), .pos_valid(pv), .pos_index(pi),
    .ctl_byte(cb), .ctl_byte_valid(cbv), .ctl_group(grp), .rec(rec), .grp(lg), .cnt(cnt),
    .busy(busy));
  function automatic logic [31:0] exp_rec(logic [31:0] x, logic [19:0] s);
    logic lr;
    lr = x[1] & ~x[3];
    return {1'b0, x[0], lr & x[2], x[3] ? 5'h00 : x[12:8], 1'b0, lr ? x[6:4] : 3'h0, s};
  endfunction : exp_rec
  task end_of_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task to(input int n);
    if (n > 200) begin
      error_cnt++;
      end_of_test();
    end
  endtask : to
  task wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
      @(posedge aclk);
      n++;
      to(n);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    resp = bresp;
  endtask : wr
  task rd(input logic [11:0] a);
    int n;
    n = 0;
    ara <= a;
    arv <= 1;
    rry <= 1;
    do begin
      @(posedge aclk);
      n++;
      to(n);
      if (arr) arv <= 0;
    end while (!rv);
    rdt = rdat;
    resp = rresp;
  endtask : rd
  initial begin
    logic [31:0] corner [3];
    int n;
    corner = '{32'h1f7f, 32'h1f77, 32'h0075};
    void'($urandom(32'h0206dd7a));
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 14; i++) begin
      c = (i < 3) ? corner[i] : $urandom & 32'h1f7f;
      if (!c[1]) c[12:8] = 5'h00;
      sn = (i == 0) ? 20'hfffff : 20'($urandom);
      slow <= i[0];
      wr(dirf_pkg::ADDR_CTX, c);
      chk({30'h0, resp}, {30'h0, dirf_pkg::RESP_OKAY});
      wr(dirf_pkg::ADDR_SERIAL, {12'h000, sn});
      go <= 1;
      @(posedge aclk);
      go <= 0;
      n = 0;
      do begin
        @(posedge aclk);
        n++;
        to(n);
      end while (busy);
      repeat (3) @(posedge aclk);
      chk({28'h0, cnt}, 32'h4);
      chk(rec, exp_rec(c, sn));
      chk({30'h0, lg}, {30'h0, dirf_pkg::RECORD_GROUP});
      rd(dirf_pkg::ADDR_RECORD);
      chk(rdt, exp_rec(c, sn));
      $display("test %0d done", i);
    end
    rd(dirf_pkg::ADDR_STATUS);
    chk(rdt, 32'h38);
    rd(12'h020);
    chk(rdt, 32'h0);
    chk({30'h0, resp}, {30'h0, dirf_pkg::RESP_SLVERR});
    end_of_test();
  end
endmodule : drive_info_record_formatter_bench
`default_nettype wire
